// [spmm_top.sv]
// power mode manager for accel, gyro, mag interface and magnetometer
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Functional notes
// - accel normal mode samples continuously
// - accel low power duty-cycles suspend and normal
// - suspend stops sampling, keeps data, bus live
// - gyro fast start-up: no acquisition, wake within 10ms
// - mag interface low power: setup config, data forces
// - mag interface normal like low power, full readout
// - mag interface suspend: no config, no force
// - force measures then returns to sleep
// - sleep keeps presets; config only in sleep
// - mag suspend clears presets, blocks force, config
// - power mode independent of data rate
// - too short gap keeps accel in normal
// - undersampling in normal mimics low power
// - awake time is settle plus averaged samples
// - all units start in suspend after reset
module spmm_top
  import spmm_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC,
  parameter int GYR_WAKE_P = GYR_WAKE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             acc_sample_en,
  output logic             acc_clk_lp,
  output logic             gyr_drive_en,
  output logic             gyr_acq_en,
  output logic             mif_cfg_access,
  output logic             mag_force,
  output logic             fifo_full_rd,
  output logic [7:0]       mag_preset
);

  function automatic logic pm_legal(input logic [1:0] tgt,
                                    input spmm_pm_e   mode,
                                    input spmm_pm_e   acc,
                                    input spmm_pm_e   gyr,
                                    input spmm_mag_e  mag);
    logic ok;
    ok = 1'b0;
    unique case (tgt)
      TGT_ACC: ok = (mode != PM_FSU) &&
                    ((mode != PM_LOW) || (gyr == PM_SUSPEND));
      TGT_GYR: ok = (mode != PM_LOW) &&
                    ((acc != PM_LOW) || (mode == PM_SUSPEND));
      TGT_MIF: ok = (mode != PM_FSU) &&
                    ((mode != PM_SUSPEND) || (mag == MG_SUSPEND));
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  spmm_pm_e    acc_reg, gyr_reg, mif_reg;
  spmm_mag_e   mag_reg;
  logic [11:0] acc_cfg_reg;
  logic [15:0] mif_cfg_reg;
  logic [7:0]  preset_reg;
  logic        refused_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] phase_reg;
  logic [31:0] gwake_reg;
  logic        gyr_ready_reg;
  logic [7:0]  fper_reg;
  logic [7:0]  meas_reg;
  logic        force_reg;
  logic        cfg_acc_reg;

  // bus decode
  wire         setup_ph  = ce && psel && !penable;
  wire         access_ph = ce && psel && penable;
  wire         wr        = access_ph && pwrite;
  wire         hit_cmd   = (paddr == OFS_CMD);
  wire         hit_acc   = (paddr == OFS_ACC_CFG);
  wire         hit_mag   = (paddr == OFS_MAG_CMD);
  wire         hit_st    = (paddr == OFS_STATUS);
  wire         hit_mif   = (paddr == OFS_MIF_CFG);
  wire         hit_any   = hit_cmd | hit_acc | hit_mag | hit_st | hit_mif;
  wire         cmd_wr    = wr && hit_cmd;
  wire         mag_wr    = wr && hit_mag;
  wire [1:0]   cmd_tgt   = pwdata[CMD_TGT_LSB +: 2];
  wire spmm_pm_e cmd_mode = spmm_pm_e'(pwdata[CMD_MODE_LSB +: 2]);
  wire [1:0]   mag_op    = pwdata[MAG_OP_LSB +: 2];

  wire cmd_ok = pm_legal(cmd_tgt, cmd_mode, acc_reg, gyr_reg, mag_reg);

  // accelerometer configuration view
  wire [3:0]   odr_code  = acc_cfg_reg[ACC_ODR_LSB +: 4];
  wire [2:0]   avg_log   = acc_cfg_reg[ACC_AVG_LSB +: 3];
  wire         acc_us    = acc_cfg_reg[ACC_US_BIT];
  wire [3:0]   settle    = acc_cfg_reg[ACC_SETTLE_LSB +: 4];
  wire [15:0]  period    = 16'h0001 << odr_code;
  wire [15:0]  awake_len = {12'h000, settle} + (16'h0001 << avg_log);
  wire         gap_short = (awake_len >= period);
  wire         tick      = ce && (tick_cnt_reg == 32'(TICK_CYC_P - 1));

  wire mif_on   = (mif_reg != PM_SUSPEND);
  wire mif_data = mif_cfg_reg[MIF_DATA_BIT];
  wire [7:0] fper = (mif_cfg_reg[MIF_PER_LSB +: 8] == 8'h00) ? 8'h01
                    : mif_cfg_reg[MIF_PER_LSB +: 8];

  // sleep and setup config gate preset writes
  wire pre_ok   = mif_on && !mif_data && (mag_reg == MG_SLEEP);
  wire sleep_ok = mif_on && (mag_reg == MG_SUSPEND);
  wire susp_ok  = mif_on && (mag_reg == MG_SLEEP);
  wire mag_ok   = (mag_op == MOP_SLEEP)   ? sleep_ok :
                  (mag_op == MOP_SUSPEND) ? susp_ok  :
                  (mag_op == MOP_PRESET)  ? pre_ok   : 1'b1;
  wire force_go = tick && mif_on && mif_data && (mag_reg == MG_SLEEP)
                  && (fper_reg == 8'h01);

  wire refuse   = (cmd_wr && !cmd_ok) || (mag_wr && !mag_ok);
  wire st_w1c   = wr && hit_st && pwdata[ST_REFUSED_BIT];

  // duty window; undersampling uses it in normal mode too
  wire duty     = (acc_reg == PM_LOW) || ((acc_reg == PM_NORMAL) && acc_us);
  wire in_win   = gap_short || (phase_reg < awake_len);

  wire [31:0] rd_mux =
    hit_cmd ? {28'h0000000, acc_reg, 2'h0} :
    hit_acc ? {20'h00000, acc_cfg_reg} :
    hit_mif ? {16'h0000, mif_cfg_reg} :
    hit_st  ? {8'h00, preset_reg, 4'h0, gap_short, gyr_ready_reg,
               acc_sample_en, refused_reg, 2'(mag_reg), 2'(mif_reg),
               2'(gyr_reg), 2'(acc_reg)} : 32'h00000000;

  // one wait-free access phase while enabled
  assign pready  = ce;
  assign pslverr = psel && penable && !hit_any;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= PM_SUSPEND;
      gyr_reg <= PM_SUSPEND;
      mif_reg <= PM_SUSPEND;
    end else if (cmd_wr && cmd_ok) begin
      // modes kept apart from rate config
      if (cmd_tgt == TGT_ACC) acc_reg <= cmd_mode;
      if (cmd_tgt == TGT_GYR) gyr_reg <= cmd_mode;
      if (cmd_tgt == TGT_MIF) mif_reg <= cmd_mode;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_cfg_reg <= ACC_CFG_RST;
      mif_cfg_reg <= MIF_CFG_RST;
    end else begin
      if (wr && hit_acc) acc_cfg_reg <= pwdata[11:0];
      if (wr && hit_mif) mif_cfg_reg <= pwdata[15:0];
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refused_reg <= 1'b0;
    end else if (refuse) begin
      refused_reg <= 1'b1;
    end else if (st_w1c) begin
      refused_reg <= 1'b0;
    end
  end

  // sample tick and duty phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 32'h00000000;
      phase_reg    <= 16'h0000;
    end else if (ce) begin
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
      if (!duty || (tick && phase_reg >= period - 16'h0001)) begin
        phase_reg <= 16'h0000;
      end else if (tick) begin
        phase_reg <= phase_reg + 16'h0001;
      end
    end
  end

  // gyro wake count, bounded by the 10ms budget
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gwake_reg     <= 32'h00000000;
      gyr_ready_reg <= 1'b0;
    end else if (ce) begin
      if (gyr_reg != PM_NORMAL) begin
        gwake_reg     <= 32'h00000000;
        gyr_ready_reg <= 1'b0;
      end else if (!gyr_ready_reg) begin
        gwake_reg     <= gwake_reg + 32'h00000001;
        gyr_ready_reg <= (gwake_reg >= 32'(GYR_WAKE_P - 1));
      end
    end
  end

  // magnetometer sequencing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mag_reg     <= MG_SUSPEND;
      preset_reg  <= 8'h00;
      fper_reg    <= 8'h01;
      meas_reg    <= 8'h00;
      force_reg   <= 1'b0;
      cfg_acc_reg <= 1'b0;
    end else if (ce) begin
      force_reg   <= force_go;
      cfg_acc_reg <= mag_wr && (mag_op == MOP_PRESET) && pre_ok;
      if (tick) begin
        fper_reg <= (fper_reg == 8'h01) ? fper : fper_reg - 8'h01;
      end
      unique case (mag_reg)
        MG_SUSPEND: begin
          preset_reg <= 8'h00;
          if (mag_wr && mag_op == MOP_SLEEP && sleep_ok) mag_reg <= MG_SLEEP;
        end
        MG_SLEEP: begin
          if (mag_wr && mag_op == MOP_SUSPEND && susp_ok) begin
            mag_reg <= MG_SUSPEND;
          end else if (force_go) begin
            mag_reg  <= MG_FORCE;
            meas_reg <= 8'(MAG_MEAS_TICKS);
          end else if (mag_wr && mag_op == MOP_PRESET && pre_ok) begin
            preset_reg <= pwdata[MAG_PRE_LSB +: 8];
          end
        end
        MG_FORCE: begin
          if (tick) begin
            meas_reg <= meas_reg - 8'h01;
            if (meas_reg == 8'h01) mag_reg <= MG_SLEEP;
          end
        end
        default: mag_reg <= MG_SUSPEND;
      endcase
    end
  end

  // full sampling in plain normal mode
  assign acc_sample_en = ((acc_reg == PM_NORMAL) && !acc_us) ||
                         (duty && in_win);
  // low power differs from undersampled normal by clock source and no full readout
  assign acc_clk_lp    = (acc_reg == PM_LOW);
  assign gyr_drive_en  = (gyr_reg == PM_NORMAL) || (gyr_reg == PM_FSU);
  // no acquisition until awake in normal
  assign gyr_acq_en    = (gyr_reg == PM_NORMAL) && gyr_ready_reg;
  assign mag_force      = force_reg;
  assign mif_cfg_access = cfg_acc_reg;
  // full readout with interface, accel or gyro in normal
  assign fifo_full_rd   = (mif_reg == PM_NORMAL) || (acc_reg == PM_NORMAL)
                          || (gyr_reg == PM_NORMAL);
  assign mag_preset     = preset_reg;

  logic [31:0] wait_cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 32'h00000000;
    end else if (ce) begin
      wait_cnt <= gyr_acq_en || (gyr_reg != PM_NORMAL) ? 32'h00000000
                  : wait_cnt + 32'h00000001;
    end
  end

  acc_lp_pair_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    acc_reg == PM_LOW |-> gyr_reg == PM_SUSPEND)
    else $error("accel low power with gyro awake");

  refuse_hold_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && !cmd_ok |=> $stable(acc_reg) && $stable(gyr_reg)
                         && $stable(mif_reg) && refused_reg)
    else $error("refused mode request changed state");

  susp_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    acc_reg == PM_SUSPEND |-> !acc_sample_en)
    else $error("accel sampling in suspend");

  acc_full_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    acc_reg == PM_NORMAL && !acc_us |-> acc_sample_en)
    else $error("accel normal mode not sampling");

  gyr_wake_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (gyr_reg == PM_FSU |-> !gyr_acq_en) and
    (wait_cnt <= 32'(GYR_WAKE_P)))
    else $error("gyro wake late or fsu acquiring");

  mif_susp_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    mif_reg == PM_SUSPEND |=> !mag_force && !mif_cfg_access)
    else $error("mag interface active in suspend");

  force_back_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $past(mag_reg) == MG_FORCE && mag_reg != MG_FORCE
      |-> mag_reg == MG_SLEEP)
    else $error("force did not return to sleep");

  mag_clear_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    mag_reg == MG_SUSPEND && ce ##1 mag_reg == MG_SUSPEND
      |-> preset_reg == 8'h00)
    else $error("presets kept in suspend");

  short_gap_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    duty && gap_short |-> acc_sample_en)
    else $error("accel suspended on short gap");

  cfg_sleep_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    mif_cfg_access |-> mag_reg == MG_SLEEP && $past(pre_ok))
    else $error("config outside sleep");

  lp_cycle_c: cover property (
    @(posedge clk_sys) disable iff (!resetn)
    acc_reg == PM_LOW && $fell(acc_sample_en));

  gyr_wake_c: cover property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(gyr_acq_en));

  mag_force_c: cover property (
    @(posedge clk_sys) disable iff (!resetn)
    mag_force ##1 mag_reg == MG_FORCE);

endmodule

// [spmm_pkg.sv]
// constants and types of the sensor power mode manager
package spmm_pkg;

  // clock and timing
  localparam int CLK_NS         = 5;
  localparam int SAMPLE_NS      = 625000;
  localparam int TICK_CYC       = SAMPLE_NS / CLK_NS;
  localparam int GYR_WAKE_NS    = 10000000;
  localparam int GYR_WAKE_CYC   = GYR_WAKE_NS / CLK_NS;
  localparam int MAG_MEAS_TICKS = 2;

  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_ACC_CFG = 8'h04;
  localparam logic [7:0] OFS_MAG_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_MIF_CFG = 8'h10;

  // mode command fields
  localparam int CMD_TGT_LSB  = 0;
  localparam int CMD_MODE_LSB = 2;
  localparam logic [1:0] TGT_ACC = 2'h0;
  localparam logic [1:0] TGT_GYR = 2'h1;
  localparam logic [1:0] TGT_MIF = 2'h2;

  // accelerometer configuration fields
  localparam int ACC_ODR_LSB    = 0;
  localparam int ACC_AVG_LSB    = 4;
  localparam int ACC_US_BIT     = 7;
  localparam int ACC_SETTLE_LSB = 8;
  localparam logic [11:0] ACC_CFG_RST = 12'h103;

  // magnetometer command fields
  localparam int MAG_OP_LSB  = 0;
  localparam int MAG_PRE_LSB = 8;
  localparam logic [1:0] MOP_SLEEP   = 2'h1;
  localparam logic [1:0] MOP_SUSPEND = 2'h2;
  localparam logic [1:0] MOP_PRESET  = 2'h3;

  // interface configuration fields
  localparam int MIF_DATA_BIT   = 0;
  localparam int MIF_PER_LSB    = 8;
  localparam logic [15:0] MIF_CFG_RST = 16'h0100;

  // status fields
  localparam int ST_REFUSED_BIT = 8;
  localparam int ST_AWAKE_BIT   = 9;
  localparam int ST_GRDY_BIT    = 10;
  localparam int ST_SHORT_BIT   = 11;
  localparam int ST_PRE_LSB     = 16;

  typedef enum logic [1:0] {PM_SUSPEND, PM_NORMAL, PM_LOW, PM_FSU} spmm_pm_e;
  typedef enum logic [1:0] {MG_SUSPEND, MG_SLEEP, MG_FORCE} spmm_mag_e;

endpackage

// [spmm_host.sv]
// host processor model: apb master issuing power mode commands
`timescale 1ns/10ps
module spmm_host
  import spmm_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; waits on pready, the bench watchdog cuts a hang
  // the model never reads the fifo
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale values would hide a slave that ignores psel
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [1:0] tgt, input logic [1:0] m);
    wr(OFS_CMD, {28'h0, m, tgt});
  endtask
endmodule

// [tb_sensor_power_mode_manager.sv]
// self-checking bench for the sensor power mode manager
`timescale 1ns/10ps
module tb_sensor_power_mode_manager
  import spmm_pkg::*;
;
  localparam int TK = 4;
  localparam int GW = 8;
  logic        clk_sys;
  logic        resetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        acc_sample_en;
  logic        acc_clk_lp;
  logic        gyr_drive_en;
  logic        gyr_acq_en;
  logic        mif_cfg_access;
  logic        mag_force;
  logic        fifo_full_rd;
  logic [7:0]  mag_preset;
  logic [2:0]  obs;
  int          err_total = 0;
  int          compares = 0;

  assign obs = {mif_cfg_access, mag_force, acc_sample_en};

  spmm_top #(.TICK_CYC_P(TK), .GYR_WAKE_P(GW)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_sample_en(acc_sample_en), .acc_clk_lp(acc_clk_lp),
    .gyr_drive_en(gyr_drive_en), .gyr_acq_en(gyr_acq_en),
    .mif_cfg_access(mif_cfg_access), .mag_force(mag_force),
    .fifo_full_rd(fifo_full_rd), .mag_preset(mag_preset));

  spmm_host u_host (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_st(input string nm, input logic [31:0] m,
                        input logic [31:0] e);
    u_host.rd(OFS_STATUS);
    chk(nm, e, u_host.rdata & m);
  endtask

  // count cycles in which an observed output is high
  task automatic cnt(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      #1;
      if (obs[sel] === 1'b1) c++;
      @(posedge clk_sys);
    end
  endtask

  task automatic t_reset;
    chk_st("status_rst", 32'h00ff07ff, 32'h0);
    chk("outs_rst", 32'h0, {acc_sample_en, gyr_drive_en, mag_preset});
    u_host.rd(OFS_ACC_CFG);
    chk("acc_cfg_rst", {20'h0, ACC_CFG_RST}, u_host.rdata);
    u_host.rd(OFS_MIF_CFG);
    chk("mif_cfg_rst", {16'h0, MIF_CFG_RST}, u_host.rdata);
  endtask

  task automatic t_acc_normal;
    int c;
    u_host.cmd(TGT_ACC, PM_NORMAL);
    u_host.wr(OFS_ACC_CFG, 32'h113);
    cnt(0, 40, c);
    chk("acc_norm_on", 40, c);
    chk("acc_norm_lp", 2'b01, {acc_clk_lp, fifo_full_rd});
    u_host.cmd(TGT_ACC, PM_SUSPEND);
    cnt(0, 20, c);
    chk("acc_susp_on", 0, c);
    u_host.rd(OFS_ACC_CFG);
    chk("acc_cfg_kept", 32'h113, u_host.rdata);
  endtask

  task automatic t_acc_duty;
    int c;
    u_host.cmd(TGT_ACC, PM_LOW);
    #1;
    chk("lp_outs", 2'b10, {acc_clk_lp, fifo_full_rd});
    cnt(0, 10, c);
    cnt(0, 64, c);
    chk("lp_duty", 24, c);
    // 200 Hz, one sample, long settle: awake fills the period
    u_host.wr(OFS_ACC_CFG, 32'h703);
    cnt(0, 10, c);
    cnt(0, 64, c);
    chk("lp_short_on", 64, c);
    chk_st("lp_short_flag", 32'h800, 32'h800);
    u_host.cmd(TGT_ACC, PM_NORMAL);
    u_host.wr(OFS_ACC_CFG, 32'h193);
    cnt(0, 10, c);
    cnt(0, 64, c);
    chk("us_duty", 24, c);
    chk("us_clk", 1'b0, acc_clk_lp);
    u_host.wr(OFS_ACC_CFG, {20'h0, ACC_CFG_RST});
    u_host.cmd(TGT_ACC, PM_SUSPEND);
  endtask

  task automatic t_refuse;
    u_host.cmd(TGT_ACC, PM_LOW);
    u_host.cmd(TGT_GYR, PM_NORMAL);
    chk_st("gyr_refused", 32'h10f, 32'h102);
    #1;
    chk("gyr_off", 1'b0, gyr_drive_en);
    u_host.wr(OFS_STATUS, 32'h100);
    u_host.cmd(TGT_ACC, PM_FSU);
    chk_st("acc_fsu_ref", 32'h103, 32'h102);
    u_host.wr(OFS_STATUS, 32'h100);
    u_host.cmd(2'h3, PM_NORMAL);
    chk_st("tgt3_ref", 32'h13f, 32'h102);
    u_host.wr(OFS_STATUS, 32'h100);
    chk_st("clear", 32'h100, 32'h0);
    u_host.cmd(TGT_ACC, PM_SUSPEND);
  endtask

  task automatic t_gyro;
    int n;
    u_host.cmd(TGT_GYR, PM_FSU);
    repeat (GW + 4) @(posedge clk_sys);
    #1;
    chk("fsu_outs", 2'b10, {gyr_drive_en, gyr_acq_en});
    u_host.cmd(TGT_GYR, PM_NORMAL);
    // ce low freezes the wake count and stalls the bus
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    chk("ce_freeze", 2'b00, {pready, gyr_acq_en});
    @(posedge clk_sys);
    ce <= 1'b1;
    n = 0;
    while (gyr_acq_en !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("gyr_wake", GW, n);
    chk_st("gyr_ready", 32'h40c, 32'h404);
    u_host.cmd(TGT_GYR, PM_SUSPEND);
  endtask

  task automatic t_mag;
    int c;
    int n;
    u_host.cmd(TGT_MIF, PM_NORMAL);
    #1;
    chk("mif_fifo", 1'b1, fifo_full_rd);
    u_host.cmd(TGT_MIF, PM_LOW);
    #1;
    chk("mif_lp_fifo", 1'b0, fifo_full_rd);
    u_host.wr(OFS_MAG_CMD, {16'h0, 8'h5a, 6'h0, MOP_PRESET});
    chk_st("pre_in_susp", 32'h1ff0100, 32'h100);
    u_host.wr(OFS_STATUS, 32'h100);
    u_host.wr(OFS_MAG_CMD, {30'h0, MOP_SLEEP});
    u_host.wr(OFS_MAG_CMD, {16'h0, 8'h5a, 6'h0, MOP_PRESET});
    cnt(2, 4, c);
    chk("cfg_pulse", 1, c);
    chk("preset", 8'h5a, mag_preset);
    u_host.wr(OFS_MIF_CFG, 32'h0401);
    n = 0;
    while (mag_force !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("force_seen", 1'b1, n < 100);
    u_host.wr(OFS_MIF_CFG, 32'h0400);
    repeat ((MAG_MEAS_TICKS + 1) * TK) @(posedge clk_sys);
    chk_st("back_sleep", 32'h0ff00c0, 32'h05a0040);
    u_host.cmd(TGT_MIF, PM_SUSPEND);
    chk_st("mif_susp_ref", 32'h130, 32'h120);
    u_host.wr(OFS_STATUS, 32'h100);
    u_host.wr(OFS_MAG_CMD, {30'h0, MOP_SUSPEND});
    chk_st("mag_susp", 32'h0ff00c0, 32'h0);
    u_host.cmd(TGT_MIF, PM_SUSPEND);
    u_host.wr(OFS_MIF_CFG, 32'h0101);
    u_host.wr(OFS_MAG_CMD, {16'h0, 8'h33, 6'h0, MOP_PRESET});
    cnt(1, 40, c);
    chk("no_force", 0, c);
    chk_st("mif_susp", 32'h1ff0130, 32'h100);
    u_host.wr(OFS_STATUS, 32'h100);
  endtask

  task automatic t_bus;
    u_host.rd(8'h14);
    chk("unmap_rd", 32'h0, u_host.rdata);
    chk("unmap_rd_err", 1'b1, u_host.rerr);
    u_host.wr(8'h14, 32'hffffffff);
    chk("unmap_wr", 1'b1, u_host.rerr);
    u_host.rd(OFS_MAG_CMD);
    chk("magcmd_rd", 32'h0, u_host.rdata);
  endtask

  task automatic finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // watchdog well beyond the several hundred cycles the run needs
  initial begin
    #100000;
    err_total++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_acc_normal();
    t_acc_duty();
    t_refuse();
    t_gyro();
    t_mag();
    t_bus();
    finish_test();
  end
endmodule
